// [rtl/boost_seq_pkg.sv]
// constants, types and register layout for the boost start-up and fault sequencer
// assumes a 250 MHz pclk and analogue comparators feeding one-bit sense flags
// Behaviour
// - pre-charge 500mA, raise to 2000mA after 750us
// - fault if target missed after 1.5ms more
// - auto start-up uses reduced limit below preset
// - pre-charge throttles at 110C, restores 10C lower
// - enable low, force low: shutdown, pass on
// - enable low, force high: clamp, block reverse
// - enable high, force low: limited pass-through
// - both high: auto boost or pass-through
// - restart falling edge: discharge, then start-up or forced-pass wait
// - lockout disables registers and output stage
// - 160C shuts all switches until cooled, except in shutdown
// - fault on start-up, regulation loss, overtemperature
// - fault stops stage, waits 1ms, retries
// - optional low pulse on open-drain fault pin
// - power good after successful start-up
// - power good drops on droop or 115C
// - any fault clears power good
// - power good high in forced pass, shutdown
// - bypass overcurrent in auto run or forced pass declares fault and restarts
// - valley limit extends boost off-time
// - valley threshold set by configuration register
// - forced pass waits for output below input
package boost_seq_pkg;
  // clock and times, each in its own unit
  localparam int CLK_PERIOD_PS  = 4000;
  localparam int PRE_LOW_US     = 750;
  localparam int PRE_HIGH_US    = 1500;
  localparam int RETRY_US       = 1000;
  localparam int MODE_SKEW_NS   = 60;
  localparam int FAULT_PULSE_NS = 1000;
  // longest times round down, least times round up
  localparam int PRE_LOW_CYC     = PRE_LOW_US * 1000000 / CLK_PERIOD_PS;
  localparam int PRE_HIGH_CYC    = PRE_HIGH_US * 1000000 / CLK_PERIOD_PS;
  localparam int RETRY_CYC       = (RETRY_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int MODE_SKEW_CYC   = (MODE_SKEW_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int FAULT_PULSE_CYC = (FAULT_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int TMR_W           = 21;
  localparam int PULSE_W         = 9;
  localparam int SKEW_W          = 5;
  // apb map
  localparam int             ADDR_W     = 8;
  localparam logic [7:0]     CTRL_OFS   = 8'h00;
  localparam logic [7:0]     STATUS_OFS = 8'h04;
  localparam logic [7:0]     FAULT_OFS  = 8'h08;
  localparam int             CTRL_PULSE_BIT = 0;
  localparam int             CTRL_FULL_BIT  = 1;
  localparam int             VALLEY_LSB     = 4;
  localparam int             VALLEY_W       = 4;
  localparam logic [3:0]     VALLEY_RESET   = 4'h8;
  localparam int             STAT_PG_BIT    = 9;
  localparam int             STAT_PIN_BIT   = 10;
  // sticky fault causes
  localparam int FLT_TIMEOUT = 0;
  localparam int FLT_REGLOSS = 1;
  localparam int FLT_THERMAL = 2;
  localparam int FLT_BYPASS  = 3;
  localparam int FLT_W       = 4;
  // accepted mode codes {enable, pass_through_force_n}
  localparam logic [1:0] MODE_AUTO   = 2'h3;
  localparam logic [1:0] MODE_FORCED = 2'h2;
  localparam int ST_W = 9;
  typedef enum logic [ST_W-1:0] {
    ST_LOCKOUT   = 9'h001,
    ST_SHUTDOWN  = 9'h002,
    ST_PRECHARGE = 9'h004,
    ST_STARTUP   = 9'h008,
    ST_AUTO_RUN  = 9'h010,
    ST_FPT_WAIT  = 9'h020,
    ST_FPT       = 9'h040,
    ST_DISCHARGE = 9'h080,
    ST_FAULT     = 9'h100
  } state_e;
  // comparator flags from the analogue side
  typedef struct packed {
    logic vout_at_vin;
    logic vout_below_preset;
    logic precharge_reg_lost;
    logic vout_below_pg;
    logic vout_discharged;
    logic vout_below_vin;
    logic vin_above_target;
    logic die_above_110;
    logic die_above_115;
    logic die_below_100;
    logic die_above_160;
    logic undervoltage_lockout;
    logic bypass_over_limit;
    logic valley_over_limit;
  } sense_s;
  // power stage controls
  typedef struct packed {
    logic                precharge_on;
    logic                precharge_high;
    logic                precharge_throttle;
    logic                startup_limit_low;
    logic                boost_on;
    logic                bypass_on;
    logic                bypass_limit_on;
    logic                reverse_block;
    logic                min_level_clamp;
    logic                discharge_on;
    logic                off_time_extend;
    logic [VALLEY_W-1:0] valley_code;
  } stage_s;
endpackage

// [rtl/boost_seq.sv]
// start-up, mode and fault sequencer with an apb control slave
// assumes pins and comparator flags are asynchronous to pclk
`timescale 1ns/10ps
module boost_seq #(
  parameter int unsigned PRE_LOW_CYCLES  = boost_seq_pkg::PRE_LOW_CYC,
  parameter int unsigned PRE_HIGH_CYCLES = boost_seq_pkg::PRE_HIGH_CYC,
  parameter int unsigned RETRY_CYCLES    = boost_seq_pkg::RETRY_CYC
) (
  input  wire logic                             pclk,
  input  wire logic                             presetn,
  input  wire logic                             psel,
  input  wire logic                             penable,
  input  wire logic                             pwrite,
  input  wire logic [boost_seq_pkg::ADDR_W-1:0] paddr,
  input  wire logic [31:0]                      pwdata,
  output logic      [31:0]                      prdata,
  output logic                                  pready,
  output logic                                  pslverr,
  input  wire logic                             enable,
  input  wire logic                             pass_through_force_n,
  input  wire logic                             output_restart_n,
  input  wire logic                             fault_flag_n_i,
  output logic                                  fault_flag_n_o,
  output logic                                  fault_flag_oe_n,
  input  wire boost_seq_pkg::sense_s            sense,
  output boost_seq_pkg::stage_s                 stage,
  output logic                                  power_good
);
  import boost_seq_pkg::*;

  localparam int SYNC_W = 4 + $bits(sense_s);
  localparam logic [TMR_W-1:0] PRE_LOW_T   = TMR_W'(PRE_LOW_CYCLES);
  localparam logic [TMR_W-1:0] PRE_TOTAL_T = TMR_W'(PRE_LOW_CYCLES + PRE_HIGH_CYCLES);
  localparam logic [TMR_W-1:0] PRE_HIGH_T  = TMR_W'(PRE_HIGH_CYCLES);
  localparam logic [TMR_W-1:0] RETRY_T     = TMR_W'(RETRY_CYCLES);
  localparam logic [SKEW_W-1:0] SKEW_T     = SKEW_W'(MODE_SKEW_CYC);
  localparam logic [PULSE_W-1:0] PULSE_T   = PULSE_W'(FAULT_PULSE_CYC);

  // refuse zero counts and pre-charge totals the timer cannot hold
  if (PRE_LOW_CYCLES < 1 || PRE_HIGH_CYCLES < 1 || RETRY_CYCLES < 1 ||
      PRE_LOW_CYCLES + PRE_HIGH_CYCLES >= (1 << TMR_W)) begin : g_bad_counts
    $error("timing counts out of range");
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic [SYNC_W-1:0]  sync1;         // first stage, read only by sync2
  logic [SYNC_W-1:0]  sync2;         // safe copy
  sense_s             s;             // synchronised flags
  logic               en_s;
  logic               ptf_s;
  logic               rst_s;
  logic               pin_s;
  logic               rst_prev;      // restart pin, one cycle late
  logic               restart_fall;
  logic [1:0]         raw_mode;
  logic [1:0]         mode_q;        // accepted mode
  logic [SKEW_W-1:0]  skew_cnt;
  state_e             state;
  state_e             next_state;
  logic [TMR_W-1:0]   tmr;           // time in current state
  logic [FLT_W-1:0]   fault_evt;
  logic [FLT_W-1:0]   fault_cause;   // sticky, write one to clear
  logic               throttle;      // pre-charge thermal hysteresis
  logic               pg_hot;        // power good thermal hysteresis
  logic [PULSE_W-1:0] pulse_cnt;
  logic [31:0]        ctrl;
  stage_s             next_stage;
  logic               next_pg;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sync1 <= '0;
      sync2 <= '0;
    end
    else
    begin
      sync1 <= {enable, pass_through_force_n, output_restart_n, fault_flag_n_i, sense};
      sync2 <= sync1;
    end
  end

  assign {en_s, ptf_s, rst_s, pin_s} = sync2[SYNC_W-1 -: 4];
  assign s            = sync2[$bits(sense_s)-1:0];
  assign raw_mode     = {en_s, ptf_s};
  assign restart_fall = rst_prev & ~rst_s;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mode_q   <= 2'h0;
      skew_cnt <= '0;
      rst_prev <= 1'b0;
    end
    else
    begin
      rst_prev <= rst_s;
      if (raw_mode == mode_q)
        skew_cnt <= '0;
      else if (skew_cnt == SKEW_T - 1'b1)
      begin
        mode_q   <= raw_mode;
        skew_cnt <= '0;
      end
      else
        skew_cnt <= skew_cnt + 1'b1;
    end
  end

  // next state and fault causes
  always_comb
  begin
    next_state = state;
    fault_evt  = '0;
    case (state)
      ST_LOCKOUT:
        next_state = ST_SHUTDOWN;
      ST_SHUTDOWN:
      begin
        if (mode_q == MODE_AUTO)
          next_state = ST_PRECHARGE;
        else if (mode_q == MODE_FORCED)
          next_state = ST_FPT_WAIT;
      end
      ST_PRECHARGE:
      begin
        if (mode_q != MODE_AUTO)
          next_state = ST_SHUTDOWN;
        else if (restart_fall)
          next_state = ST_DISCHARGE;
        else if (s.precharge_reg_lost)
          fault_evt[FLT_REGLOSS] = 1'b1;
        else if (s.vout_at_vin)
          next_state = ST_STARTUP;
        else if (tmr == PRE_TOTAL_T - 1'b1)
          fault_evt[FLT_TIMEOUT] = 1'b1;
      end
      ST_STARTUP:
      begin
        if (mode_q != MODE_AUTO)
          next_state = ST_SHUTDOWN;
        else if (restart_fall)
          next_state = ST_DISCHARGE;
        else if (!s.vout_below_preset)
          next_state = ST_AUTO_RUN;
        else if (tmr == PRE_HIGH_T - 1'b1)
          fault_evt[FLT_TIMEOUT] = 1'b1;
      end
      ST_AUTO_RUN, ST_FPT:
      begin
        if (mode_q != (state == ST_FPT ? MODE_FORCED : MODE_AUTO))
          next_state = ST_SHUTDOWN;
        else if (restart_fall)
          next_state = ST_DISCHARGE;
        else if (stage.bypass_on && s.bypass_over_limit)
          fault_evt[FLT_BYPASS] = 1'b1;
      end
      ST_FPT_WAIT:
      begin
        if (mode_q != MODE_FORCED)
          next_state = ST_SHUTDOWN;
        else if (restart_fall)
          next_state = ST_DISCHARGE;
        else if (s.vout_below_vin)
          next_state = ST_FPT;
      end
      ST_DISCHARGE:
      begin
        if (s.vout_discharged)
          next_state = ST_SHUTDOWN;
      end
      ST_FAULT:
      begin
        if (tmr >= RETRY_T - 1'b1 && !s.die_above_160)
          next_state = ST_SHUTDOWN;
      end
      default:
        next_state = ST_LOCKOUT;
    endcase
    if (s.die_above_160 && state != ST_LOCKOUT && state != ST_SHUTDOWN)
      fault_evt[FLT_THERMAL] = (state != ST_FAULT);
    if (fault_evt != '0)
      next_state = ST_FAULT;
    if (s.die_above_160 && state == ST_FAULT)
      next_state = ST_FAULT;
    if (s.undervoltage_lockout)
    begin
      next_state = ST_LOCKOUT;
      fault_evt  = '0;
    end
  end

  // state register and shared timer
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state <= ST_LOCKOUT;
      tmr   <= '0;
    end
    else
    begin
      state <= next_state;
      if (next_state != state)
        tmr <= '0;
      else if (tmr != '1)
        tmr <= tmr + 1'b1;
    end
  end

  // thermal hysteresis flags, set wins over clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      throttle <= 1'b0;
      pg_hot   <= 1'b0;
    end
    else
    begin
      // throttle band 110C down to 100C
      throttle <= s.die_above_110 | (throttle & ~s.die_below_100);
      // power good band 115C down to 100C
      pg_hot   <= s.die_above_115 | (pg_hot & ~s.die_below_100);
    end
  end

  // stage controls from current state
  always_comb
  begin
    next_stage = '0;
    next_stage.precharge_on       = (state == ST_PRECHARGE);
    next_stage.precharge_high     = (state == ST_PRECHARGE) && (tmr >= PRE_LOW_T);
    next_stage.precharge_throttle = (state == ST_PRECHARGE) && throttle;
    next_stage.startup_limit_low  = (state == ST_STARTUP) && s.vout_below_preset &&
                                    !ctrl[CTRL_FULL_BIT];
    next_stage.boost_on           = (state == ST_STARTUP) ||
                                    ((state == ST_AUTO_RUN) && !s.vin_above_target);
    // pass path on in low-draw shutdown
    next_stage.bypass_on          = ((state == ST_SHUTDOWN) && !mode_q[0]) ||
                                    (state == ST_FPT) ||
                                    ((state == ST_AUTO_RUN) && s.vin_above_target);
    next_stage.bypass_limit_on    = (state == ST_FPT) ||
                                    ((state == ST_AUTO_RUN) && s.vin_above_target);
    next_stage.min_level_clamp    = (state == ST_SHUTDOWN) && mode_q[0];
    next_stage.reverse_block      = ((state == ST_SHUTDOWN) && mode_q[0]) ||
                                    (state == ST_FPT_WAIT);
    next_stage.discharge_on       = (state == ST_DISCHARGE);
    next_stage.off_time_extend    = next_stage.boost_on && s.valley_over_limit;
    next_stage.valley_code        = ctrl[VALLEY_LSB +: VALLEY_W];
  end

  // forced pass and shutdown hold it high
  assign next_pg = (state == ST_SHUTDOWN) || (state == ST_FPT_WAIT) || (state == ST_FPT) ||
                   ((state == ST_AUTO_RUN) && !s.vout_below_pg && !pg_hot);

  // registered stage and power good
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      stage      <= '0;
      power_good <= 1'b0;
    end
    else
    begin
      stage      <= next_stage;
      power_good <= next_pg;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pulse_cnt <= '0;
    else if (fault_evt != '0 && ctrl[CTRL_PULSE_BIT])
      pulse_cnt <= PULSE_T;
    else if (pulse_cnt != '0)
      pulse_cnt <= pulse_cnt - 1'b1;
  end

  assign fault_flag_n_o  = 1'b0;
  assign fault_flag_oe_n = (pulse_cnt == '0);

  // apb decode, zero wait states
  wire acc      = psel & penable;
  wire hit_ctrl = (paddr == CTRL_OFS);
  wire hit_stat = (paddr == STATUS_OFS);
  wire hit_flt  = (paddr == FAULT_OFS);
  wire hit      = hit_ctrl | hit_stat | hit_flt;
  wire wr_ok    = acc & pwrite & hit & ~s.undervoltage_lockout;
  wire [FLT_W-1:0] flt_clr = (wr_ok & hit_flt) ? pwdata[FLT_W-1:0] : '0;
  wire [31:0] rd_mux = hit_ctrl ? ctrl :
                       hit_stat ? {21'h0, pin_s, power_good, state} :
                       hit_flt  ? {28'h0, fault_cause} : 32'h0;

  assign pready  = 1'b1;
  assign pslverr = acc & ~hit;

  // registers; read data latched in setup
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl        <= {24'h0, VALLEY_RESET, 4'h0};
      fault_cause <= '0;
      prdata      <= 32'h0;
    end
    else
    begin
      if (wr_ok && hit_ctrl)
        ctrl <= {24'h0, pwdata[VALLEY_LSB +: VALLEY_W], 2'h0, pwdata[CTRL_FULL_BIT:0]};
      // new cause beats a clear in the same cycle
      fault_cause <= (fault_cause & ~flt_clr) | fault_evt;
      if (psel && !penable)
        prdata <= rd_mux;
    end
  end

  // checks
  sequence s_fault_entry;
    $rose(state == ST_FAULT);
  endsequence
  property p_pre_low;
    (state == ST_PRECHARGE && tmr < PRE_LOW_T) |=> !stage.precharge_high;
  endproperty
  a_pre_low: assert property (p_pre_low) else $error("raised current too early");
  property p_pre_high;
    (state == ST_PRECHARGE && tmr >= PRE_LOW_T) |=> stage.precharge_high;
  endproperty
  a_pre_high: assert property (p_pre_high) else $error("current not raised");
  property p_timeout;
    (state == ST_PRECHARGE && next_state == ST_FAULT && tmr == PRE_TOTAL_T - 1'b1 &&
     !s.precharge_reg_lost && !s.die_above_160) |=> fault_cause[FLT_TIMEOUT];
  endproperty
  a_timeout: assert property (p_timeout) else $error("timeout cause missing");
  property p_retry;
    (state == ST_FAULT && next_state == ST_SHUTDOWN) |-> tmr >= RETRY_T - 1'b1;
  endproperty
  a_retry: assert property (p_retry) else $error("retry before wait");
  property p_fault_off;
    s_fault_entry ##1 (state == ST_FAULT) |-> !stage.boost_on && !stage.bypass_on;
  endproperty
  a_fault_off: assert property (p_fault_off) else $error("stage on in fault");
  property p_pg_fault;
    (state == ST_FAULT) |=> !power_good;
  endproperty
  a_pg_fault: assert property (p_pg_fault) else $error("power good in fault");
  property p_pg_forced;
    (state == ST_FPT) |=> power_good;
  endproperty
  a_pg_forced: assert property (p_pg_forced) else $error("power good low in pass");
  property p_pg_hot;
    (pg_hot && state == ST_AUTO_RUN) |=> !power_good;
  endproperty
  a_pg_hot: assert property (p_pg_hot) else $error("power good while hot");
  property p_pulse;
    (fault_evt != '0 && ctrl[CTRL_PULSE_BIT]) |=> !fault_flag_oe_n [*8];
  endproperty
  a_pulse: assert property (p_pulse) else $error("fault pulse too short");
  property p_hold_bypass;
    (state == ST_FPT_WAIT) |=> !stage.bypass_on && stage.reverse_block;
  endproperty
  a_hold_bypass: assert property (p_hold_bypass) else $error("bypass closed early");
  property p_skew;
    $changed(mode_q) |-> $past(skew_cnt) == SKEW_T - 1'b1;
  endproperty
  a_skew: assert property (p_skew) else $error("mode taken before skew");
endmodule

// [test/boost_host_model.sv]
// host side model: drives the mode and restart pins, resolves the fault pin
// assumes requests arrive from the bench and change just after pclk edges
`timescale 1ns/10ps
module boost_host_model (
  input  wire logic       pclk,
  input  wire logic [1:0] mode_req,     // {enable, pass_through_force_n} wanted
  input  wire logic       restart_req,  // high asks for a restart pulse
  input  wire logic       fault_o,      // device pull level
  input  wire logic       fault_oe_n,   // low while device pulls
  output logic            enable,
  output logic            pass_through_force_n,
  output logic            output_restart_n,
  output logic            fault_pin     // resolved open-drain wire
);
  initial
  begin
    enable = 1'b0;
    pass_through_force_n = 1'b1;
    output_restart_n = 1'b1;
  end
  // both pins same edge
  // one edge moves both mode pins, so skew stays far under the allowance
  always @(posedge pclk)
  begin
    enable <= mode_req[1];
    pass_through_force_n <= mode_req[0];
    output_restart_n <= ~restart_req;
  end
  // pull-up on fault pin
  // released pin floats high through the pull-up, never to a stale value
  assign fault_pin = fault_oe_n ? 1'b1 : fault_o;
endmodule

// [test/boost_seq_tb.sv]
// self-checking bench for the boost sequencer: apb reads noted in a queue
// assumes short sim counts 40/80/30 and a bench-driven comparator bundle
`timescale 1ns/10ps
module boost_seq_tb;
  import boost_seq_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, r;
  logic pready, pslverr, en, ptf_n, rst_n, fpin, f_o, f_oe_n, power_good;
  logic err;                     // pslverr taken at the access edge
  logic [1:0] mode_req = 2'h1;   // shutdown with clamp first
  logic restart_req = 0;
  sense_s sense = '0;
  stage_s stage;
  logic [31:0] exp_q[$], msk_q[$];  // notes of expected read data
  int failures = 0, n_tests = 0, cyc = 0, pulse_len = 0;
  logic [3:0] vc;
  boost_seq #(.PRE_LOW_CYCLES(40), .PRE_HIGH_CYCLES(80), .RETRY_CYCLES(30)) boost_seq_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .enable(en), .pass_through_force_n(ptf_n), .output_restart_n(rst_n),
    .fault_flag_n_i(fpin), .fault_flag_n_o(f_o), .fault_flag_oe_n(f_oe_n),
    .sense(sense), .stage(stage), .power_good(power_good));
  boost_host_model boost_host_model_inst (.pclk(pclk), .mode_req(mode_req),
    .restart_req(restart_req), .fault_o(f_o), .fault_oe_n(f_oe_n), .enable(en),
    .pass_through_force_n(ptf_n), .output_restart_n(rst_n), .fault_pin(fpin));
  initial
  begin
    forever #2 pclk = ~pclk;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      failures++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic finish_test();
    $display("failures %0d of %0d checks", failures, n_tests);
    if (failures == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // one apb transfer; reads leave a note (value, mask) for the watcher
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d,
                     input logic [31:0] e, input logic [31:0] m);
    if (!w)
    begin
      exp_q.push_back(e);
      msk_q.push_back(m);
    end
    @(posedge pclk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    err = pslverr;
    psel <= 0; penable <= 0;
  endtask
  // poll status until the wanted state shows, then confirm it
  task automatic wait_st(input state_e s);
    int i;
    for (i = 0; i < 400; i++)
    begin
      apb(STATUS_OFS, 0, 0, 0, 0);
      if (r[8:0] === s) break;
    end
    chk({23'h0, r[8:0]}, {23'h0, s});
  endtask
  // watcher: takes the oldest note at each completed read
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc > 30000)
    begin
      failures++;
      finish_test();
    end
    if (!f_oe_n) pulse_len++;
    if (psel && penable && pready && !pwrite && exp_q.size() > 0)
    begin
      if (msk_q[0] != 0) chk(prdata & msk_q[0], exp_q[0]);
      void'(exp_q.pop_front());
      void'(msk_q.pop_front());
    end
  end
  initial
  begin
    void'($urandom(9945));
    sense.die_below_100 = 1;
    sense.vout_below_preset = 1;
    repeat (8) @(posedge pclk);
    presetn <= 1;
    apb(CTRL_OFS, 0, 0, 32'h80, 32'hFF);
    wait_st(ST_SHUTDOWN);
    // mode pins need sync plus the skew filter before shutdown flavour shows
    repeat (20) @(posedge pclk);
    chk({stage.min_level_clamp, stage.reverse_block, stage.bypass_on}, 3'b110);
    apb(STATUS_OFS, 0, 0, 32'h600, 32'h600);
    apb(8'h0C, 0, 0, 0, 32'hFFFFFFFF);
    chk(err, 1);
    vc = $urandom;
    apb(CTRL_OFS, 1, {24'h0, vc, 4'h1}, 0, 0);
    apb(CTRL_OFS, 0, 0, {24'h0, vc, 4'h1}, 32'hFF);
    chk(stage.valley_code, vc);
    mode_req <= 2'h0;
    repeat (30) @(posedge pclk);
    chk(stage.bypass_on, 1);
    mode_req <= MODE_AUTO;
    wait_st(ST_PRECHARGE);
    repeat (20) @(posedge pclk);
    chk({stage.precharge_on, stage.precharge_high}, 2'b10);
    repeat (30) @(posedge pclk);
    chk(stage.precharge_high, 1);
    pulse_len = 0;
    wait_st(ST_FAULT);
    apb(STATUS_OFS, 0, 0, 0, 32'h200);
    apb(FAULT_OFS, 0, 0, 32'h1, 32'hF);
    chk({stage.boost_on, stage.bypass_on}, 0);
    apb(FAULT_OFS, 1, 32'hF, 0, 0);
    apb(FAULT_OFS, 0, 0, 0, 32'hF);
    sense.vout_at_vin <= 1;
    wait_st(ST_STARTUP);
    chk(stage.startup_limit_low, 1);
    sense.vout_below_preset <= 0;
    wait_st(ST_AUTO_RUN);
    apb(STATUS_OFS, 0, 0, 32'h200, 32'h200);
    // let the whole fault pulse run out before counting it
    repeat (260) @(posedge pclk);
    chk(pulse_len, 250);
    sense.die_above_115 <= 1;
    repeat (8) @(posedge pclk);
    chk(power_good, 0);
    sense.die_above_115 <= 0;
    repeat (8) @(posedge pclk);
    chk(power_good, 1);
    restart_req <= 1;
    wait_st(ST_DISCHARGE);
    restart_req <= 0;
    chk(stage.discharge_on, 1);
    sense.vout_discharged <= 1;
    wait_st(ST_AUTO_RUN);
    mode_req <= MODE_FORCED;
    wait_st(ST_FPT_WAIT);
    chk(stage.bypass_on, 0);
    sense.vout_below_vin <= 1;
    wait_st(ST_FPT);
    chk({stage.bypass_on, stage.bypass_limit_on, power_good}, 3'b111);
    sense.bypass_over_limit <= 1;
    wait_st(ST_FAULT);
    sense.bypass_over_limit <= 0;
    apb(FAULT_OFS, 0, 0, 32'h8, 32'h8);
    sense.undervoltage_lockout <= 1;
    wait_st(ST_LOCKOUT);
    apb(CTRL_OFS, 1, 32'h0, 0, 0);
    apb(CTRL_OFS, 0, 0, {24'h0, vc, 4'h1}, 32'hFF);
    finish_test();
  end
endmodule
